/* File: tws_pkg.sv */
// Package for the two-wire slave interrupt, capability and timing registers.
// Assumes a 32-bit register port with byte offsets and a single core clock.
package tws_pkg;
    // ==========================================
    // Register offsets
    localparam logic [7:0] OFF_STATUS_FLAGS     = 8'h18;
    localparam logic [7:0] OFF_INT_ENABLE_SET   = 8'h1c;
    localparam logic [7:0] OFF_INT_ENABLE_CLEAR = 8'h20;
    localparam logic [7:0] OFF_INTERRUPT_MASK   = 8'h24;
    localparam logic [7:0] OFF_STATUS_CLEAR     = 8'h28;
    localparam logic [7:0] OFF_CAPABILITY       = 8'h2c;
    localparam logic [7:0] OFF_MODULE_VERSION   = 8'h30;
    localparam logic [7:0] OFF_FAST_HOLD        = 8'h34;
    localparam logic [7:0] OFF_STD_FAST_SLEW    = 8'h38;
    localparam logic [7:0] OFF_FAST_SLEW        = 8'h3c;

    // ==========================================
    // Field layouts and reset values
    localparam logic [31:0] MASK_BITS       = 32'h00fb_71cb;
    localparam logic [31:0] CLEARABLE_BITS  = 32'h00fb_71c8;
    localparam logic [31:0] LEVEL_BITS      = 32'h0000_0027;
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
    localparam int          HOLD_LSB        = 16;
    localparam int          HOLD_MSB        = 23;
    localparam int          FILTER_LSB      = 28;
    localparam int          FILTER_MSB      = 29;
    localparam int          SLEW_LSB        = 8;
    localparam int          SLEW_MSB        = 9;
    localparam int          DRIVE_LSB       = 0;
    localparam int          DRIVE_MSB       = 2;
    localparam logic [1:0]  FLT_STD_FAST    = 2'h2;
    localparam logic [1:0]  FLT_FAST_PLUS   = 2'h3;
    localparam logic [1:0]  FLT_HIGH_SPEED  = 2'h1;
    localparam int          VERSION_LSB     = 0;
    localparam int          VERSION_MSB     = 11;
    localparam int          VARIANT_LSB     = 16;
    localparam int          VARIANT_MSB     = 19;
    localparam int          SLAVE_INSTANCES = 2;

    // ==========================================
    // Types
    typedef enum logic [1:0] {
        FILT_NONE,
        FILT_STD_FAST,
        FILT_FAST_PLUS,
        FILT_HIGH_SPEED
    } tws_filter_t;

    typedef struct packed {
        logic [1:0] data_slew_limit;
        logic [2:0] data_pulldown_strength;
    } tws_pad_cfg_t;
endpackage

/* File: tws_regs.sv */
// Interrupt mask, status clear, capability, version, hold timing and slew
// registers of the two-wire slave. Assumes the slave engine on the same
// clock gives flag events; the bus clock line arrives raw from the pin.

// How it works
// - Enable-set write ones set mask bits
// - Enable-clear write ones clear mask bits
// - Mask one enables source; reset zero
// - Status-clear one clears flag and request
// - Status-clear zero changes nothing
// - Capability bit zero shows high-speed support
// - Version reads fixed number, inert variant
// - High-speed drive delayed by hold count
// - Hold delay times ack and data bits
// - Std filter: 2 std/fast, 3 plus
// - Std register drives slew and pull-down
// - High-speed register: slew, drive, filter 1
// - Only first two instances are slaves
module tws_regs #(
    parameter int          INSTANCE_ID    = 0,
    parameter logic        HS_IMPLEMENTED = 1'b1,
    parameter logic [11:0] VERSION_NUM    = 12'h123,  // Arbitrary value
    parameter logic [3:0]  VARIANT_NUM    = 4'h0      // Arbitrary value
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst,
    input  wire logic [7:0]            i_addr,
    input  wire logic [31:0]           i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic [31:0]                o_rdata,
    input  wire logic [31:0]           i_flag_events,
    input  wire logic [31:0]           i_level_status,
    input  wire logic                  i_hs_mode,
    input  wire logic                  i_drive_pending,
    input  wire logic                  i_bus_clock_line,
    output logic                       o_data_drive,
    output logic                       o_irq,
    output tws_pkg::tws_filter_t       o_filter_mode,
    output tws_pkg::tws_pad_cfg_t      o_pad_cfg
);
    // ==========================================
    // Slave capability of this instance
    // gate slave function
    localparam logic SLAVE_OK = (INSTANCE_ID < tws_pkg::SLAVE_INSTANCES);

    // ==========================================
    // Address decode
    wire logic wr_set_w    = i_wr && (i_addr == tws_pkg::OFF_INT_ENABLE_SET);
    wire logic wr_clr_w    = i_wr && (i_addr == tws_pkg::OFF_INT_ENABLE_CLEAR);
    wire logic wr_scr_w    = i_wr && (i_addr == tws_pkg::OFF_STATUS_CLEAR);
    wire logic wr_hold_w   = i_wr && (i_addr == tws_pkg::OFF_FAST_HOLD);
    wire logic wr_sfslew_w = i_wr && (i_addr == tws_pkg::OFF_STD_FAST_SLEW);
    wire logic wr_hsslew_w = i_wr && (i_addr == tws_pkg::OFF_FAST_SLEW);

    logic [31:0] mask_r;
    logic [31:0] mask_nxt;
    logic [31:0] flags_r;
    logic [31:0] flags_nxt;
    logic [7:0]  hold_r;
    logic [31:0] sfslew_r;
    logic [31:0] hsslew_r;
    logic [31:0] rdata_r;
    logic        irq_r;

    // ==========================================
    // Interrupt mask
    // set on enable write
    assign mask_nxt = wr_set_w ? (mask_r | (i_wdata & tws_pkg::MASK_BITS)) :
                      wr_clr_w ? (mask_r & ~i_wdata) : mask_r;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            mask_r <= tws_pkg::ZERO_WORD;
        end else begin
            mask_r <= SLAVE_OK ? mask_nxt : tws_pkg::ZERO_WORD;
        end
    end

    // ==========================================
    // Sticky status flags
    // clear on written one
    wire logic [31:0] scr_clear_w = wr_scr_w ? i_wdata : tws_pkg::ZERO_WORD;
    assign flags_nxt = ((flags_r & ~scr_clear_w) | i_flag_events) & tws_pkg::CLEARABLE_BITS;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            flags_r <= tws_pkg::ZERO_WORD;
        end else begin
            flags_r <= SLAVE_OK ? flags_nxt : tws_pkg::ZERO_WORD;
        end
    end

    wire logic [31:0] level_w  = i_level_status & tws_pkg::LEVEL_BITS;
    wire logic [31:0] status_w = flags_r | level_w;

    // ==========================================
    // Interrupt line
    // unmasked flag raises line
    wire logic irq_nxt_w = |((flags_nxt | level_w) & mask_nxt);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= SLAVE_OK && irq_nxt_w;
        end
    end

    // ==========================================
    // Timing and slew registers
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_r <= 8'h00;
        end else if (wr_hold_w) begin
            hold_r <= i_wdata[tws_pkg::HOLD_MSB:tws_pkg::HOLD_LSB];
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sfslew_r <= tws_pkg::ZERO_WORD;
        end else if (wr_sfslew_w) begin
            sfslew_r <= i_wdata;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            hsslew_r <= tws_pkg::ZERO_WORD;
        end else if (wr_hsslew_w) begin
            hsslew_r <= i_wdata;
        end
    end

    // ==========================================
    // Pad configuration and filter selection
    wire logic [1:0] sf_filt_w = sfslew_r[tws_pkg::FILTER_MSB:tws_pkg::FILTER_LSB];
    wire logic [1:0] hs_filt_w = hsslew_r[tws_pkg::FILTER_MSB:tws_pkg::FILTER_LSB];

    tws_pkg::tws_filter_t filt_w;
    assign filt_w = i_hs_mode ? ((hs_filt_w == tws_pkg::FLT_HIGH_SPEED) ?
                                 tws_pkg::FILT_HIGH_SPEED : tws_pkg::FILT_NONE) :
                    (sf_filt_w == tws_pkg::FLT_STD_FAST)  ? tws_pkg::FILT_STD_FAST :
                    (sf_filt_w == tws_pkg::FLT_FAST_PLUS) ? tws_pkg::FILT_FAST_PLUS :
                    tws_pkg::FILT_NONE;

    wire logic [31:0] slew_src_w = i_hs_mode ? hsslew_r : sfslew_r;
    tws_pkg::tws_pad_cfg_t pad_w;
    assign pad_w.data_slew_limit        = slew_src_w[tws_pkg::SLEW_MSB:tws_pkg::SLEW_LSB];
    assign pad_w.data_pulldown_strength = slew_src_w[tws_pkg::DRIVE_MSB:tws_pkg::DRIVE_LSB];

    tws_pkg::tws_filter_t  filt_r;
    tws_pkg::tws_pad_cfg_t pad_r;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            filt_r <= tws_pkg::FILT_NONE;
            pad_r  <= '0;
        end else begin
            filt_r <= filt_w;
            pad_r  <= pad_w;
        end
    end

    // ==========================================
    // Bus clock line synchroniser and fall detect
    logic scl_meta_r;
    logic scl_sync_r;
    logic scl_prev_r;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_meta_r <= 1'b1;
            scl_sync_r <= 1'b1;
            scl_prev_r <= 1'b1;
        end else begin
            scl_meta_r <= i_bus_clock_line;
            scl_sync_r <= scl_meta_r;
            scl_prev_r <= scl_sync_r;
        end
    end

    wire logic scl_fall_w = scl_prev_r && !scl_sync_r;

    // ==========================================
    // Data hold counter
    logic [7:0] hold_cnt_r;
    logic       hold_busy_r;
    logic       drive_r;

    wire logic start_w  = SLAVE_OK && scl_fall_w && i_drive_pending;
    wire logic expire_w = hold_busy_r && (hold_cnt_r == 8'h00);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_cnt_r  <= 8'h00;
            hold_busy_r <= 1'b0;
            drive_r     <= 1'b0;
        end else begin
            drive_r <= start_w ? !i_hs_mode : expire_w;
            if (start_w) begin
                hold_cnt_r  <= hold_r;
                hold_busy_r <= i_hs_mode;
            end else if (hold_busy_r) begin
                hold_cnt_r  <= hold_cnt_r - 8'h01;
                hold_busy_r <= !expire_w;
            end
        end
    end

    // ==========================================
    // Read mux
    wire logic [31:0] cap_w = {31'h0000_0000, HS_IMPLEMENTED};
    wire logic [31:0] ver_w = {12'h000, VARIANT_NUM, 4'h0, VERSION_NUM};
    wire logic [31:0] hold_word_w = {8'h00, hold_r, 16'h0000};

    wire logic [31:0] rd_sel_w =
        !SLAVE_OK                                ? tws_pkg::ZERO_WORD :
        (i_addr == tws_pkg::OFF_STATUS_FLAGS)    ? status_w :
        (i_addr == tws_pkg::OFF_INTERRUPT_MASK)  ? mask_r :
        (i_addr == tws_pkg::OFF_CAPABILITY)      ? cap_w :
        (i_addr == tws_pkg::OFF_MODULE_VERSION)  ? ver_w :
        (i_addr == tws_pkg::OFF_FAST_HOLD)       ? hold_word_w :
        (i_addr == tws_pkg::OFF_STD_FAST_SLEW)   ? sfslew_r :
        (i_addr == tws_pkg::OFF_FAST_SLEW)       ? hsslew_r :
        tws_pkg::ZERO_WORD;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_r <= tws_pkg::ZERO_WORD;
        end else begin
            rdata_r <= i_rd ? rd_sel_w : tws_pkg::ZERO_WORD;
        end
    end

    assign o_rdata       = rdata_r;
    assign o_irq         = irq_r;
    assign o_data_drive  = drive_r;
    assign o_filter_mode = filt_r;
    assign o_pad_cfg     = pad_r;

    // ==========================================
    // Assertions
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_hs_start;
        start_w && i_hs_mode;
    endsequence

    sequence s_hold_count;
        hold_busy_r && (hold_cnt_r != 8'h00) && !start_w;
    endsequence

    sequence s_hold_expire;
        hold_busy_r && (hold_cnt_r == 8'h00) && !start_w;
    endsequence

    a_mask_set: assert property (
        SLAVE_OK && wr_set_w
        |=> ((mask_r & $past(i_wdata) & tws_pkg::MASK_BITS) == ($past(i_wdata) & tws_pkg::MASK_BITS)))
        else $error("mask bit not set by enable write");

    a_mask_clear: assert property (wr_clr_w |=> ((mask_r & $past(i_wdata)) == tws_pkg::ZERO_WORD))
        else $error("mask bit not cleared by disable write");

    a_mask_hold: assert property (!wr_set_w && !wr_clr_w |=> $stable(mask_r))
        else $error("mask changed without a write");

    a_flag_clear: assert property (
        wr_scr_w && ((i_wdata & ~i_flag_events & tws_pkg::CLEARABLE_BITS) != 0)
        |=> ((flags_r & $past(i_wdata) & ~$past(i_flag_events)) == tws_pkg::ZERO_WORD))
        else $error("flag survived status clear");

    a_flag_set_wins: assert property (
        SLAVE_OK && ((i_flag_events & tws_pkg::CLEARABLE_BITS) != 0)
        |=> ((flags_r & $past(i_flag_events & tws_pkg::CLEARABLE_BITS))
             == $past(i_flag_events & tws_pkg::CLEARABLE_BITS)))
        else $error("flag event lost to a same-cycle clear");

    a_flag_keep: assert property (
        ((flags_r & ~scr_clear_w) != 0)
        |=> ((flags_r & $past(flags_r & ~scr_clear_w)) == $past(flags_r & ~scr_clear_w)))
        else $error("flag lost without a one written");

    a_irq_level: assert property (
        ##1 (irq_r == (SLAVE_OK && (((flags_r | ($past(i_level_status) & tws_pkg::LEVEL_BITS)) & mask_r) != 0))))
        else $error("interrupt line disagrees with flags and mask");

    a_cap_read: assert property (
        i_rd && (i_addr == tws_pkg::OFF_CAPABILITY) && SLAVE_OK
        |=> (rdata_r == {31'h0000_0000, HS_IMPLEMENTED}))
        else $error("capability read wrong");

    a_version_read: assert property (
        i_rd && (i_addr == tws_pkg::OFF_MODULE_VERSION) && SLAVE_OK
        |=> (rdata_r[tws_pkg::VERSION_MSB:tws_pkg::VERSION_LSB] == VERSION_NUM))
        else $error("version read wrong");

    a_version_variant: assert property (
        i_rd && (i_addr == tws_pkg::OFF_MODULE_VERSION) && SLAVE_OK
        |=> (rdata_r[tws_pkg::VARIANT_MSB:tws_pkg::VARIANT_LSB] == VARIANT_NUM))
        else $error("variant field read wrong");

    a_hold_load: assert property (
        s_hs_start |=> hold_busy_r && (hold_cnt_r == $past(hold_r)))
        else $error("hold counter not loaded on line fall");

    a_hold_count: assert property (
        s_hold_count |=> hold_busy_r && (hold_cnt_r == $past(hold_cnt_r) - 8'h01))
        else $error("hold counter did not step down");

    a_hold_delay: assert property (
        s_hold_expire |=> drive_r && !hold_busy_r)
        else $error("drive not issued after hold count");

    a_std_drive: assert property (
        start_w && !i_hs_mode |=> drive_r)
        else $error("standard-mode drive not immediate");

    a_hs_no_early: assert property (
        s_hs_start |=> !drive_r)
        else $error("high-speed drive issued before hold count");

    a_drive_cause: assert property (drive_r |-> $past(expire_w) || $past(start_w && !i_hs_mode))
        else $error("drive pulse without cause");

    a_std_filter: assert property (
        !i_hs_mode && (sf_filt_w == tws_pkg::FLT_FAST_PLUS)
        |=> (filt_r == tws_pkg::FILT_FAST_PLUS))
        else $error("fast-mode-plus filter not selected");

    a_std_fast_filter: assert property (
        !i_hs_mode && (sf_filt_w == tws_pkg::FLT_STD_FAST)
        |=> (filt_r == tws_pkg::FILT_STD_FAST))
        else $error("standard filter not selected");

    a_std_reserved: assert property (
        !i_hs_mode && (sf_filt_w != tws_pkg::FLT_STD_FAST) && (sf_filt_w != tws_pkg::FLT_FAST_PLUS)
        |=> (filt_r == tws_pkg::FILT_NONE))
        else $error("reserved standard filter value selected a filter");

    a_sf_pad: assert property (
        !i_hs_mode |=> (pad_r.data_pulldown_strength == $past(sfslew_r[tws_pkg::DRIVE_MSB:tws_pkg::DRIVE_LSB])))
        else $error("standard drive strength not applied");

    a_sf_slew: assert property (
        !i_hs_mode |=> (pad_r.data_slew_limit == $past(sfslew_r[tws_pkg::SLEW_MSB:tws_pkg::SLEW_LSB])))
        else $error("standard slew not applied");

    a_hs_filter: assert property (
        i_hs_mode && (hs_filt_w == tws_pkg::FLT_HIGH_SPEED)
        |=> (filt_r == tws_pkg::FILT_HIGH_SPEED))
        else $error("high-speed filter not selected");

    a_hs_reserved: assert property (
        i_hs_mode && (hs_filt_w != tws_pkg::FLT_HIGH_SPEED)
        |=> (filt_r == tws_pkg::FILT_NONE))
        else $error("reserved high-speed filter value selected a filter");

    a_hs_pad: assert property (
        i_hs_mode |=> (pad_r.data_slew_limit == $past(hsslew_r[tws_pkg::SLEW_MSB:tws_pkg::SLEW_LSB])))
        else $error("high-speed slew not applied");

    a_hs_drive: assert property (
        i_hs_mode |=> (pad_r.data_pulldown_strength == $past(hsslew_r[tws_pkg::DRIVE_MSB:tws_pkg::DRIVE_LSB])))
        else $error("high-speed drive strength not applied");

    a_master_only: assert property (!SLAVE_OK |-> !irq_r && !drive_r && rdata_r == tws_pkg::ZERO_WORD)
        else $error("master-only instance acted as slave");
endmodule

/* File: tws_bus_master_model.sv */
// Far-side model: an external bus master toggling the bus clock line.
// Assumes the line is pulled up, so it rests high outside frames.
module tws_bus_master_model (
    input  wire logic i_frame,
    output logic      o_bus_clock_line
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================
    // Clock line, 160 ns period while a frame runs
    initial begin
        o_bus_clock_line = 1'b1;
        forever begin
            if (i_frame !== 1'b1) begin
                @(posedge i_frame);
                #3;
            end
            #80 o_bus_clock_line = 1'b0;
            #80 o_bus_clock_line = 1'b1;
        end
    end
endmodule

/* File: tws_regs_test.sv */
// Self-checking bench for the two-wire slave register block.
// Assumes a 50 MHz core clock and the far-side clock line model.
module tws_regs_test;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================
    // Signals
    logic                  i_core_clk;
    logic                  i_rst;
    logic [7:0]            i_addr;
    logic [31:0]           i_wdata;
    logic                  i_wr;
    logic                  i_rd;
    logic [31:0]           o_rdata;
    logic [31:0]           rdata_2;
    logic [31:0]           i_flag_events;
    logic [31:0]           i_level_status;
    logic                  i_hs_mode;
    logic                  i_drive_pending;
    logic                  bus_clock_line;
    logic                  frame;
    logic                  o_data_drive;
    logic                  o_irq;
    logic                  irq_2;
    tws_pkg::tws_filter_t  o_filter_mode;
    tws_pkg::tws_pad_cfg_t o_pad_cfg;
    int                    n_errors;
    int                    checked;
    int                    n_falls;
    int                    n_pulses;
    int                    dly;
    int                    d_std;
    time                   t_fall;
    logic [1:0]            flt_std [4];
    logic [1:0]            flt_fast [4];

    // ==========================================
    // Instances
    tws_regs #(.VERSION_NUM(12'h123), .VARIANT_NUM(4'h0)) u_tws_regs (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_flag_events(i_flag_events),
        .i_level_status(i_level_status), .i_hs_mode(i_hs_mode), .i_drive_pending(i_drive_pending),
        .i_bus_clock_line(bus_clock_line), .o_data_drive(o_data_drive), .o_irq(o_irq),
        .o_filter_mode(o_filter_mode), .o_pad_cfg(o_pad_cfg));
    tws_regs #(.INSTANCE_ID(2)) u_tws_regs_2 (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata_2), .i_flag_events(i_flag_events),
        .i_level_status(i_level_status), .i_hs_mode(i_hs_mode), .i_drive_pending(i_drive_pending),
        .i_bus_clock_line(bus_clock_line), .o_data_drive(), .o_irq(irq_2),
        .o_filter_mode(), .o_pad_cfg());
    tws_bus_master_model u_tws_bus_master_model (.i_frame(frame), .o_bus_clock_line(bus_clock_line));

    // ==========================================
    // Clock and drive-pulse monitor
    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end
    always @(negedge bus_clock_line) begin
        t_fall = $time;
        n_falls++;
    end
    always @(posedge i_core_clk) begin
        if (o_data_drive === 1'b1) begin
            dly = int'(($time - t_fall) / 20);
            n_pulses++;
        end
    end

    // ==========================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask
    task automatic event_pulse(input logic [31:0] v);
        @(posedge i_core_clk);
        i_flag_events <= v;
        @(posedge i_core_clk);
        i_flag_events <= 32'h0000_0000;
        #1;
    endtask
    task automatic measure(output int d);
        int n;
        n_falls = 0;
        n_pulses = 0;
        frame <= 1'b1;
        for (n = 0; n < 400 && n_pulses < 3; n++) @(posedge i_core_clk);
        frame <= 1'b0;
        repeat (30) @(posedge i_core_clk);
        if (n_pulses < 3) begin
            n_errors++;
            finish_test();
        end
        d = dly;
        chk(32'(n_pulses), 32'(n_falls));
    endtask
    task automatic finish_test();
        $display("Checks %0d, errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        flt_std = '{2'h0, 2'h0, 2'h1, 2'h2};
        flt_fast = '{2'h0, 2'h3, 2'h0, 2'h0};
        {i_rst, i_wr, i_rd, i_hs_mode, frame} = 5'h10;
        {i_addr, i_wdata, i_flag_events, i_level_status} = '0;
        i_drive_pending = 1'b1;
        {n_errors, checked, n_falls, n_pulses, dly} = '0;
        t_fall = 0;
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'b0;
        // Reset values and map
        rd(tws_pkg::OFF_INTERRUPT_MASK, 32'h0000_0000);
        rd(tws_pkg::OFF_CAPABILITY, 32'h0000_0001);
        rd(tws_pkg::OFF_MODULE_VERSION, 32'h0000_0123);
        rd(tws_pkg::OFF_FAST_HOLD, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        rd(tws_pkg::OFF_STATUS_CLEAR, 32'h0000_0000);
        chk(32'(o_irq), 32'h0);
        // Mask set and clear
        wr(tws_pkg::OFF_INT_ENABLE_SET, tws_pkg::MASK_BITS);
        wr(tws_pkg::OFF_INTERRUPT_MASK, 32'h0000_0000);
        rd(tws_pkg::OFF_INTERRUPT_MASK, tws_pkg::MASK_BITS);
        wr(tws_pkg::OFF_INT_ENABLE_CLEAR, 32'h0000_0008);
        wr(tws_pkg::OFF_INT_ENABLE_SET, 32'h0000_0000);
        rd(tws_pkg::OFF_INTERRUPT_MASK, tws_pkg::MASK_BITS & 32'hffff_fff7);
        wr(tws_pkg::OFF_INT_ENABLE_CLEAR, 32'hffff_ffff);
        rd(tws_pkg::OFF_INTERRUPT_MASK, 32'h0000_0000);
        // Interrupt raise, mask, clear
        event_pulse(32'h0000_0008);
        chk(32'(o_irq), 32'h0);
        rd(tws_pkg::OFF_STATUS_FLAGS, 32'h0000_0008);
        wr(tws_pkg::OFF_INT_ENABLE_SET, 32'h0000_0008);
        #1 chk(32'(o_irq), 32'h1);
        chk(32'(irq_2), 32'h0);
        rd(tws_pkg::OFF_CAPABILITY, 32'h0000_0001);
        chk(rdata_2, 32'h0000_0000);
        wr(tws_pkg::OFF_STATUS_CLEAR, 32'hffff_fff7);
        #1 chk(32'(o_irq), 32'h1);
        wr(tws_pkg::OFF_STATUS_CLEAR, 32'h0000_0008);
        #1 chk(32'(o_irq), 32'h0);
        event_pulse(32'h0080_0000);
        chk(32'(o_irq), 32'h0);
        wr(tws_pkg::OFF_INT_ENABLE_SET, 32'h0080_0000);
        #1 chk(32'(o_irq), 32'h1);
        wr(tws_pkg::OFF_INT_ENABLE_CLEAR, 32'h0080_0000);
        #1 chk(32'(o_irq), 32'h0);
        // Same-edge set and clear, live level source
        wr(tws_pkg::OFF_INT_ENABLE_SET, 32'h0002_0002);
        rd(tws_pkg::OFF_INTERRUPT_MASK, 32'h0002_000a);
        @(posedge i_core_clk);
        i_flag_events <= 32'h0002_0000;
        i_wr <= 1'b1;
        i_addr <= tws_pkg::OFF_STATUS_CLEAR;
        i_wdata <= 32'h0002_0000;
        @(posedge i_core_clk);
        i_flag_events <= 32'h0000_0000;
        i_wr <= 1'b0;
        #1 chk(32'(o_irq), 32'h1);
        rd(tws_pkg::OFF_STATUS_FLAGS, 32'h0082_0000);
        wr(tws_pkg::OFF_STATUS_CLEAR, 32'h0002_0000);
        #1 chk(32'(o_irq), 32'h0);
        i_level_status <= 32'h0000_0002;
        @(posedge i_core_clk);
        #1 chk(32'(o_irq), 32'h1);
        rd(tws_pkg::OFF_STATUS_FLAGS, 32'h0080_0002);
        i_level_status <= 32'h0000_0000;
        // Filter and pad settings, both register sets
        for (int v = 0; v < 4; v++) begin
            i_hs_mode <= 1'b0;
            wr(tws_pkg::OFF_STD_FAST_SLEW, (32'(v) << 28) | 32'h0000_0105);
            wr(tws_pkg::OFF_FAST_SLEW, (32'(v) << 28) | 32'h0000_0203);
            rd(tws_pkg::OFF_STD_FAST_SLEW, (32'(v) << 28) | 32'h0000_0105);
            chk(32'(o_filter_mode), 32'(flt_std[v]));
            chk(32'(o_pad_cfg), 32'h0000_000d);
            i_hs_mode <= 1'b1;
            rd(tws_pkg::OFF_FAST_SLEW, (32'(v) << 28) | 32'h0000_0203);
            chk(32'(o_filter_mode), 32'(flt_fast[v]));
            chk(32'(o_pad_cfg), 32'h0000_0013);
        end
        // Data hold delay in high-speed mode
        wr(tws_pkg::OFF_FAST_HOLD, 32'h0002_0000);
        rd(tws_pkg::OFF_FAST_HOLD, 32'h0002_0000);
        i_hs_mode <= 1'b0;
        measure(d_std);
        i_hs_mode <= 1'b1;
        measure(dly);
        chk(32'(dly - d_std), 32'd3);
        // No drive without a pending bit
        i_drive_pending <= 1'b0;
        n_pulses = 0;
        frame <= 1'b1;
        repeat (40) @(posedge i_core_clk);
        frame <= 1'b0;
        repeat (30) @(posedge i_core_clk);
        chk(32'(n_pulses), 32'h0);
        finish_test();
    end
endmodule
